// >>> bench/ccu_pin_drv.sv
// Pin-side model that drives the two unit pins with clean edges.
`timescale 1ns/1ps

module ccu_pin_drv (
  input  wire logic       clk_sys,
  output logic      [1:0] pin
);
  // ----------
  // Edge drive
  // ----------
  // Each level is held at least nine cycles so that the three-stage synchroniser always sees it.
  initial pin = 2'h0;

  task automatic lvl(input int u, input logic b);
    @(posedge clk_sys);
    pin[u] <= b;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic edges(input int u, input int n);
    repeat (n) begin
      lvl(u, 1'b1);
      lvl(u, 1'b0);
    end
  endtask
endmodule

// >>> bench/ccu_top_bench.sv
// Self-checking bench for the two capture/compare units.
`timescale 1ns/1ps

module ccu_top_bench;
  logic                  clk_sys;
  logic                  rst_n;
  ccu_pkg::ccu_bus_req_s avs_req;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [1:0]            unit_pin_in;
  logic [1:0]            compare_out;
  logic [1:0]            event_flag;
  logic [15:0]           tmr;
  logic [15:0]           tmr_nv;
  logic                  tmr_ld;
  logic                  tmr_run;
  logic                  adc_enable;
  logic                  timer1_clear;
  logic                  adc_start;
  logic [31:0]           rd;
  logic [15:0]           v;
  logic [15:0]           seen;
  logic                  out;
  int                    err_count;
  int                    cmp_count;
  int                    clr_cnt;
  int                    adc_cnt;
  int                    c0;
  int                    a0;

  ccu_pin_drv pins (.clk_sys(clk_sys), .pin(unit_pin_in));

  ccu_top uut (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .avs_req        (avs_req),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .unit_pin_in    (unit_pin_in),
    .compare_out    (compare_out),
    .event_flag     (event_flag),
    .timer1_count   (tmr),
    .adc_enable     (adc_enable),
    .timer1_clear   (timer1_clear),
    .adc_start      (adc_start)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // -----------
  // Timer model
  // -----------
  // Timer runs synchronously in the system clock domain, as the units require.
  always @(posedge clk_sys) begin
    clr_cnt <= clr_cnt + int'(timer1_clear);
    adc_cnt <= adc_cnt + int'(adc_start);
    if (timer1_clear) begin
      tmr <= 16'h0000;
    end else if (tmr_ld) begin
      tmr <= tmr_nv;
    end else if (tmr_run) begin
      tmr <= tmr + 16'h0001;
    end
  end

  // -------
  // Helpers
  // -------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One bus transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    avs_req.read       <= ~w;
    avs_req.write      <= w;
    avs_req.address    <= {ix, 2'h0};
    avs_req.byteenable <= 4'hf;
    avs_req.writedata  <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      report_and_stop();
    end
    rd = avs_readdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  function automatic logic [5:0] ix(input int u, input int k);
    return (u == 1 ? ccu_pkg::IDX_U2_LO : ccu_pkg::IDX_U1_LO) + 6'(k);
  endfunction

  function automatic logic cmp_exp(input logic [3:0] m, input logic prev);
    case (m)
      ccu_pkg::MODE_CMP_SET: return 1'b1;
      ccu_pkg::MODE_CMP_CLR, ccu_pkg::MODE_OFF: return 1'b0;
      default: return prev;
    endcase
  endfunction

  task automatic tset(input logic [15:0] val, input logic run);
    @(posedge clk_sys);
    tmr_nv  <= val;
    tmr_ld  <= 1'b1;
    tmr_run <= run;
    @(posedge clk_sys);
    tmr_ld  <= 1'b0;
  endtask

  task automatic rdv(input int u, output logic [15:0] q);
    bus(1'b0, ix(u, 0), 8'h00);
    q[7:0] = rd[7:0];
    bus(1'b0, ix(u, 1), 8'h00);
    q[15:8] = rd[7:0];
  endtask

  // Zero is written first so each run starts from a cleared prescaler.
  task automatic ps(input int u, input logic [3:0] ma, input int pre, input logic z, input logic [3:0] mb,
                    input int need);
    bus(1'b1, ix(u, 2), 8'h00);
    bus(1'b1, ix(u, 2), {4'h0, ma});
    pins.edges(u, pre);
    if (z) bus(1'b1, ix(u, 2), 8'h00);
    bus(1'b1, ix(u, 2), {4'h0, mb});
    bus(1'b1, ccu_pkg::IDX_FLAGS, 8'h03);
    pins.edges(u, need - 1);
    chk("early prescaled flag", 32'(event_flag[u]), 32'h0);
    pins.edges(u, 1);
    chk("prescaled flag", 32'(event_flag[u]), 32'h1);
  endtask

  // -------------
  // Main sequence
  // -------------
  initial begin
    logic [3:0] ml [6];
    ml = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_SW, ccu_pkg::MODE_CMP_CLR,
           ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_OFF, ccu_pkg::MODE_CMP_TRIG};
    rst_n = 1'b0;
    avs_req = '0;
    tmr = 16'h0000;
    tmr_nv = 16'h0000;
    tmr_ld = 1'b0;
    tmr_run = 1'b0;
    adc_enable = 1'b1;
    err_count = 0;
    cmp_count = 0;
    clr_cnt = 0;
    adc_cnt = 0;
    void'($urandom(40));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ix(k / 3, k % 3), 8'h00);
      chk("reset value", rd, 32'h0);
    end
    bus(1'b1, 6'h3f, 8'h5a);
    bus(1'b0, 6'h3f, 8'h00);
    chk("unmapped read", rd, 32'h0);
    bus(1'b1, ix(0, 2), 8'hff);
    bus(1'b0, ix(0, 2), 8'h00);
    chk("control readback", rd, 32'h3f);
    repeat (6) @(posedge clk_sys);
    chk("duty mode idle", 32'({compare_out[0], event_flag[0]}), 32'h0);
    for (int u = 0; u < 2; u++) begin
      v = 16'($urandom);
      tset(v, 1'b0);
      bus(1'b1, ix(u, 2), {4'h0, ccu_pkg::MODE_CAP_RISE});
      bus(1'b1, ccu_pkg::IDX_FLAGS, 8'h03);
      pins.edges(u, 1);
      tset(~v, 1'b0);
      pins.edges(u, 1);
      rdv(u, seen);
      chk("captured value", 32'(seen), {16'h0, ~v});
      bus(1'b0, ccu_pkg::IDX_FLAGS, 8'h00);
      chk("flags", rd, 32'h1 << u);
      bus(1'b1, ccu_pkg::IDX_FLAGS, 8'(1 << u));
      @(posedge clk_sys);
      chk("flag cleared", 32'(event_flag[u]), 32'h0);
      bus(1'b1, ix(u, 2), {4'h0, ccu_pkg::MODE_CAP_FALL});
      bus(1'b1, ccu_pkg::IDX_FLAGS, 8'h03);
      pins.lvl(u, 1'b1);
      chk("flag on rise", 32'(event_flag[u]), 32'h0);
      tset(v, 1'b0);
      pins.lvl(u, 1'b0);
      chk("flag on fall", 32'(event_flag[u]), 32'h1);
      rdv(u, seen);
      chk("falling capture", 32'(seen), 32'(v));
      ps(u, ccu_pkg::MODE_CAP_R4, 0, 1'b0, ccu_pkg::MODE_CAP_R4, 4);
      ps(u, ccu_pkg::MODE_CAP_R16, 0, 1'b0, ccu_pkg::MODE_CAP_R16, 16);
      ps(u, ccu_pkg::MODE_CAP_R4, 2, 1'b1, ccu_pkg::MODE_CAP_R4, 4);
      ps(u, ccu_pkg::MODE_CAP_R4, 2, 1'b0, ccu_pkg::MODE_CAP_R16, 14);
      v = 16'($urandom);
      tset(v + 16'h0040, 1'b0);
      bus(1'b1, ix(u, 2), 8'h00);
      bus(1'b1, ix(u, 0), v[7:0]);
      bus(1'b1, ix(u, 1), v[15:8]);
      rdv(u, seen);
      chk("value readback", 32'(seen), 32'(v));
      out = 1'b0;
      foreach (ml[i]) begin
        adc_enable <= 1'($urandom);
        tset(v + 16'h0040, 1'b0);
        bus(1'b1, ix(u, 2), {4'h0, ml[i]});
        bus(1'b1, ccu_pkg::IDX_FLAGS, 8'h03);
        c0 = clr_cnt;
        a0 = adc_cnt;
        tset(v, 1'b0);
        repeat (6) @(posedge clk_sys);
        out = cmp_exp(ml[i], out);
        chk("compare pin", 32'(compare_out[u]), 32'(out));
        chk("compare flag", 32'(event_flag[u]), 32'(ml[i] != ccu_pkg::MODE_OFF));
        chk("timer clears", 32'(clr_cnt - c0), 32'(ml[i] == ccu_pkg::MODE_CMP_TRIG));
        chk("timer count", 32'(tmr), ml[i] == ccu_pkg::MODE_CMP_TRIG ? 32'h0 : 32'(v));
        chk("conversion starts", 32'(adc_cnt - a0),
            32'(ml[i] == ccu_pkg::MODE_CMP_TRIG && u == 1 && adc_enable));
        bus(1'b1, ccu_pkg::IDX_FLAGS, 8'h03);
        repeat (4) @(posedge clk_sys);
        chk("single action", 32'(event_flag[u]), 32'h0);
      end
      bus(1'b1, ix(u, 2), 8'h00);
    end
    report_and_stop();
  end
endmodule

// >>> verilog/ccu_pkg.sv
// Package with register map, mode codes and bus carrier for the capture/compare unit.
package ccu_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_U1_LO   = 6'h15;
  localparam logic [5:0] IDX_U1_HI   = 6'h16;
  localparam logic [5:0] IDX_U1_CTRL = 6'h17;
  localparam logic [5:0] IDX_U2_LO   = 6'h1b;
  localparam logic [5:0] IDX_U2_HI   = 6'h1c;
  localparam logic [5:0] IDX_U2_CTRL = 6'h1d;
  localparam logic [5:0] IDX_FLAGS   = 6'h20;

  // ----------------------------------------------------------------
  // Control field layout and reset values.
  // ----------------------------------------------------------------
  localparam int         CTRL_W       = 6;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] VALUE_RST    = 8'h00;
  localparam logic [3:0] PSC_RST      = 4'h0;
  localparam logic [3:0] PSC_LAST4    = 4'h3;
  localparam logic [3:0] PSC_LAST16   = 4'hf;
  localparam logic [1:0] PSC_LAST4_LO = 2'h3;

  // ----------------------------------------------------------------
  // Mode select codes.
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SW   = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] GRP_CAPTURE   = 2'h1;
  localparam logic [1:0] GRP_COMPARE   = 2'h2;
  localparam logic [1:0] GRP_PWM       = 2'h3;

  // ----------------------------------------------------------------
  // Avalon-MM request carrier.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ccu_bus_req_s;

endpackage

// >>> verilog/ccu_top.sv
// Two capture/compare units behind an Avalon-MM slave.
//
// Function
// - 16-bit value from low and high bytes
// - Second unit same, except trigger action
// - Mode 0000 turns unit off, clears compare latch and prescaler
// - Capture on fall, rise, 4th, 16th rise
// - Compare set, clear or flag only
// - Mode 1011 triggers special event on match
// - Mode 11xx drives no logic; bits 5-4 stored only
// - Capture copies timer count into value
// - Capture sets flag; software clears it
// - New capture overwrites unread value
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps count, may flag
// - Compare value against timer continuously
// - Control zero forces compare latch low
// - Flag-only compare leaves pin untouched
// - First unit trigger clears timer count
// - Second trigger also starts conversion
`timescale 1ns/1ps

module ccu_unit #(
  parameter bit IS_SECOND = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        pin_in,
  input  wire logic [15:0] timer1_count,
  input  wire logic        wr_ctrl,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  input  wire logic        clr_flag,
  output logic [5:0]       ctrl,
  output logic [15:0]      value,
  output logic             flag,
  output logic             cmp_out,
  output logic             trig_hit
);

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection.
  // ----------------------------------------------------------------
  logic [2:0] pin_sync;
  logic       pin_lvl;
  logic       pin_stable;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], pin_in};
    end
  end

  assign pin_stable = (pin_sync[1] == pin_sync[2]);
  assign rise       = pin_stable & pin_sync[2] & ~pin_lvl;
  assign fall       = pin_stable & ~pin_sync[2] & pin_lvl;

  // The pin is watched whatever its direction, so port writes can capture.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_lvl <= 1'b0;
    end else if (pin_stable) begin
      pin_lvl <= pin_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------
  logic [3:0] mode;
  logic       is_cap;
  logic       is_cmp;
  logic [3:0] psc;
  logic       cap_evt;
  logic       match;
  logic       match_d;
  logic       hit;

  assign mode   = ctrl[3:0];
  assign is_cap = (mode[3:2] == ccu_pkg::GRP_CAPTURE);
  assign is_cmp = (mode[3:2] == ccu_pkg::GRP_COMPARE);

  // Bits 5-4 are stored for the duty value only; 11xx drives no logic here.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ccu_pkg::CTRL_RST[5:0];
    end else if (wr_ctrl) begin
      ctrl <= wdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Capture prescaler and event selection.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psc <= ccu_pkg::PSC_RST;
    end else if (!is_cap) begin
      psc <= ccu_pkg::PSC_RST;
    end else if (rise) begin
      psc <= psc + 4'h1;
    end
  end

  always_comb begin
    case (mode)
      ccu_pkg::MODE_CAP_FALL: cap_evt = fall;
      ccu_pkg::MODE_CAP_RISE: cap_evt = rise;
      ccu_pkg::MODE_CAP_R4:   cap_evt = rise & (psc[1:0] == ccu_pkg::PSC_LAST4_LO);
      ccu_pkg::MODE_CAP_R16:  cap_evt = rise & (psc == ccu_pkg::PSC_LAST16);
      default:                cap_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Compare match, once per match.
  // ----------------------------------------------------------------
  assign match    = (timer1_count == value);
  assign hit      = is_cmp & match & ~match_d;
  assign trig_hit = hit & (mode == ccu_pkg::MODE_CMP_TRIG);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_d <= 1'b0;
    end else begin
      match_d <= match;
    end
  end

  // ----------------------------------------------------------------
  // Value register; a capture beats a bus write in the same cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value <= {ccu_pkg::VALUE_RST, ccu_pkg::VALUE_RST};
    end else if (cap_evt) begin
      value <= timer1_count;
    end else begin
      if (wr_lo) begin
        value[7:0] <= wdata;
      end
      if (wr_hi) begin
        value[15:8] <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare output latch, separate from any port data latch.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_out <= 1'b0;
    end else if (mode == ccu_pkg::MODE_OFF) begin
      cmp_out <= 1'b0;
    end else if (hit && mode == ccu_pkg::MODE_CMP_SET) begin
      cmp_out <= 1'b1;
    end else if (hit && mode == ccu_pkg::MODE_CMP_CLR) begin
      cmp_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event flag; an event in the clearing cycle wins.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (cap_evt || hit) begin
      flag <= 1'b1;
    end else if (clr_flag) begin
      flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_off_clears;
    mode == ccu_pkg::MODE_OFF |=> !cmp_out && psc == ccu_pkg::PSC_RST;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("Off mode left state set.");

  property p_psc_idle;
    !is_cap |=> psc == ccu_pkg::PSC_RST;
  endproperty
  a_psc_idle: assert property (p_psc_idle) else $error("Prescaler not cleared outside capture.");

  property p_capture_value;
    cap_evt |=> value == $past(timer1_count);
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("Capture did not load timer count.");

  property p_capture_flag;
    cap_evt |=> flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("Capture did not set flag.");

  property p_cap16;
    mode == ccu_pkg::MODE_CAP_R16 && rise && psc != ccu_pkg::PSC_LAST16 |-> !cap_evt;
  endproperty
  a_cap16: assert property (p_cap16) else $error("Capture before sixteenth edge.");

  property p_cmp_set;
    hit && mode == ccu_pkg::MODE_CMP_SET |=> cmp_out && flag;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("Set-on-match failed.");

  property p_cmp_clr;
    hit && mode == ccu_pkg::MODE_CMP_CLR |=> !cmp_out && flag;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("Clear-on-match failed.");

  property p_cmp_sw;
    hit && mode == ccu_pkg::MODE_CMP_SW |=> cmp_out == $past(cmp_out) && flag;
  endproperty
  a_cmp_sw: assert property (p_cmp_sw) else $error("Flag-only compare touched pin.");

  property p_once;
    hit |=> !hit;
  endproperty
  a_once: assert property (p_once) else $error("Compare acted twice on one match.");

  property p_write_lo;
    wr_lo && !cap_evt |=> value[7:0] == $past(wdata);
  endproperty
  a_write_lo: assert property (p_write_lo) else $error("Low byte write lost.");

  c_capture: cover property (cap_evt);
  c_hit:     cover property (hit && mode == ccu_pkg::MODE_CMP_SET);
  c_trig:    cover property (trig_hit);

endmodule

module ccu_top (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire ccu_pkg::ccu_bus_req_s avs_req,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [1:0]            unit_pin_in,
  output logic [1:0]                 compare_out,
  output logic [1:0]                 event_flag,
  input  wire logic [15:0]           timer1_count,
  input  wire logic                  adc_enable,
  output logic                       timer1_clear,
  output logic                       adc_start
);

  // ----------------------------------------------------------------
  // Avalon slave: one wait state, write and read data on the second edge.
  // ----------------------------------------------------------------
  logic       req;
  logic       ack;
  logic       wr_take;
  logic       wr_lane;
  logic [5:0] idx;
  logic [5:0] ctrl [2];
  logic [15:0] value [2];
  logic [1:0] hit_trig;

  assign req             = avs_req.read | avs_req.write;
  assign avs_waitrequest = req & ~ack;
  assign idx             = avs_req.address[7:2];
  assign wr_take         = avs_req.write & ack;
  assign wr_lane         = wr_take & avs_req.byteenable[0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_req.read && !ack) begin
      case (idx)
        ccu_pkg::IDX_U1_LO:   avs_readdata <= {24'h0, value[0][7:0]};
        ccu_pkg::IDX_U1_HI:   avs_readdata <= {24'h0, value[0][15:8]};
        ccu_pkg::IDX_U1_CTRL: avs_readdata <= {26'h0, ctrl[0]};
        ccu_pkg::IDX_U2_LO:   avs_readdata <= {24'h0, value[1][7:0]};
        ccu_pkg::IDX_U2_HI:   avs_readdata <= {24'h0, value[1][15:8]};
        ccu_pkg::IDX_U2_CTRL: avs_readdata <= {26'h0, ctrl[1]};
        ccu_pkg::IDX_FLAGS:   avs_readdata <= {30'h0, event_flag};
        default:              avs_readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Units.
  // ----------------------------------------------------------------
  ccu_unit #(.IS_SECOND(1'b0)) u_unit1 (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (unit_pin_in[0]),
    .timer1_count (timer1_count),
    .wr_ctrl      (wr_lane && idx == ccu_pkg::IDX_U1_CTRL),
    .wr_lo        (wr_lane && idx == ccu_pkg::IDX_U1_LO),
    .wr_hi        (wr_lane && idx == ccu_pkg::IDX_U1_HI),
    .wdata        (avs_req.writedata[7:0]),
    .clr_flag     (wr_lane && idx == ccu_pkg::IDX_FLAGS && avs_req.writedata[0]),
    .ctrl         (ctrl[0]),
    .value        (value[0]),
    .flag         (event_flag[0]),
    .cmp_out      (compare_out[0]),
    .trig_hit     (hit_trig[0])
  );

  ccu_unit #(.IS_SECOND(1'b1)) u_unit2 (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (unit_pin_in[1]),
    .timer1_count (timer1_count),
    .wr_ctrl      (wr_lane && idx == ccu_pkg::IDX_U2_CTRL),
    .wr_lo        (wr_lane && idx == ccu_pkg::IDX_U2_LO),
    .wr_hi        (wr_lane && idx == ccu_pkg::IDX_U2_HI),
    .wdata        (avs_req.writedata[7:0]),
    .clr_flag     (wr_lane && idx == ccu_pkg::IDX_FLAGS && avs_req.writedata[1]),
    .ctrl         (ctrl[1]),
    .value        (value[1]),
    .flag         (event_flag[1]),
    .cmp_out      (compare_out[1]),
    .trig_hit     (hit_trig[1])
  );

  // ----------------------------------------------------------------
  // Special event trigger outputs; no timer overflow flag is raised.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer1_clear <= 1'b0;
      adc_start    <= 1'b0;
    end else begin
      timer1_clear <= |hit_trig;
      adc_start    <= hit_trig[1] & adc_enable;
    end
  end

  default clocking cbt @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_adc_with_clear;
    adc_start |-> timer1_clear;
  endproperty
  a_adc_with_clear: assert property (p_adc_with_clear) else $error("Conversion start without timer clear.");

  property p_trig1_clear;
    hit_trig[0] && !hit_trig[1] |=> timer1_clear && !adc_start;
  endproperty
  a_trig1_clear: assert property (p_trig1_clear) else $error("First trigger misbehaved.");

  c_adc: cover property (adc_start);

endmodule
